// ---- verilog/axd_map.vh ----
`ifndef AXD_MAP_VH
`define AXD_MAP_VH

// sense sample width from the front-end converter
`define AXD_SW            12
// offset added to the held sample, in sense lsbs
`define AXD_OFFSET        12'h010
// sampling interval, in ns
`define AXD_TSAMPLE_NS    1000
// detection and discharge phase length, in ms
`define AXD_PHASE_MS      32
`define AXD_CLK_MHZ       250
// cycles per sample interval: 1000 ns at 250 MHz
`define AXD_SAMPLE_CYC    16'h00fa
// cycles per phase: 32 ms at 250 MHz
`define AXD_PHASE_CYC     24'h7a1200
// floor below which the startup source can no longer sink current
`define AXD_FLOOR         12'h040
`define AXD_TW            24
`define AXD_ST_DETECT     1'b0
`define AXD_ST_DISCH      1'b1

`endif

// ---- verilog/axd_sync.v ----
`timescale 1ns/1ps
`default_nettype none
`include "axd_map.vh"
module axd_sync (
  input  wire                  clk,
  input  wire                  arst_n,
  input  wire [`AXD_SW-1:0]    din,
  output wire [`AXD_SW-1:0]    dout
);
  reg [`AXD_SW-1:0] s1_q;
  reg [`AXD_SW-1:0] s2_q;

  // a multi-bit word from the converter is assumed stable between strobes
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= {`AXD_SW{1'b0}};
      s2_q <= {`AXD_SW{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule
`default_nettype wire

// ---- verilog/axd_slope.v ----
`timescale 1ns/1ps
`default_nettype none
`include "axd_map.vh"
module axd_slope (
  input  wire                  clk,
  input  wire                  arst_n,
  input  wire [`AXD_SW-1:0]    sample,
  output reg                   cmp_q
);
  localparam [15:0] SAMPLE_CYC = `AXD_SAMPLE_CYC;

  reg [15:0]        tick_q;
  reg [`AXD_SW-1:0] hold_q;
  reg [`AXD_SW:0]   sum;

  always @* begin
    sum = {1'b0, hold_q} + {1'b0, `AXD_OFFSET}; // see [R2]
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 16'h0000;
      hold_q <= {`AXD_SW{1'b1}};
      cmp_q  <= 1'b0;
    end else begin
      // no hysteresis: resolution comes from interval and offset only
      if (tick_q >= SAMPLE_CYC - 16'h0001) begin // see [R3]
        tick_q <= 16'h0000;
        hold_q <= sample; // see [R1]
      end else begin
        tick_q <= tick_q + 16'h0001;
      end
      // only a rise above held+offset drives the output high
      cmp_q <= ({1'b0, sample} > sum); // see [R7]
    end
  end
endmodule
`default_nettype wire

// ---- verilog/axd_x2_discharge.v ----
// What this block does
// [R1] keep a delayed held sample and compare it with the live sample
// [R2] add fixed offset to held sample as comparator reference
// [R3] sampling interval and offset set the slope resolution
// [R4] comparator crossing restarts timer and drops the dc flag
// [R5] timer cleared on both rising and falling comparator edges
// [R6] timer expiry with no edge means only dc is present
// [R7] pulses mean rising slope; steady low means slow or falling
// [R8] discharge stays armed in every controller mode
// [R9] the same timer bounds each discharge phase
// [R10] discharge repeats until line returns or sense drops below floor
// [R11] 32 ms detection alternates with 32 ms discharge
// [R12] discharge phase turns on the startup current source
// [R13] dc at end of detection enters discharge if sense is at or above floor, then back with cleared timer
`timescale 1ns/1ps
`default_nettype none
`include "axd_map.vh"
module axd_x2_discharge #(
  parameter [`AXD_TW-1:0] PHASE_CYC = `AXD_PHASE_CYC
) (
  input  wire                  CLK,
  input  wire                  ARST_N,
  input  wire [`AXD_SW-1:0]    LINE_SENSE_PIN,
  output wire                  SLOPE_COMPARE_OUT,
  output wire                  DC_PRESENT_FLAG,
  output wire                  DISCHARGE_CURRENT,
  output wire                  DISCHARGE_PHASE
);
  //////////////////////////////////////////////////////////////////////////
  // sequencer states
  localparam [0:0]         ST_DETECT = 1'b0;
  localparam [0:0]         ST_DISCH  = 1'b1;

  // timer constants at full timer width
  localparam [`AXD_TW-1:0] T_ZERO    = {`AXD_TW{1'b0}};
  localparam [`AXD_TW-1:0] T_ONE     = {{(`AXD_TW-1){1'b0}}, 1'b1};

  //////////////////////////////////////////////////////////////////////////
  // next count of the shared phase timer
  function [`AXD_TW-1:0] f_bump;
    input [`AXD_TW-1:0] cnt;
    begin
      f_bump = cnt + T_ONE;
    end
  endfunction

  // timer stands on the last cycle of a phase
  function f_done;
    input [`AXD_TW-1:0] cnt;
    input [`AXD_TW-1:0] limit;
    begin
      f_done = (cnt >= limit - T_ONE);
    end
  endfunction

  // any change of the comparator, rising or falling
  function f_toggle;
    input now;
    input was;
    begin
      f_toggle = now ^ was;
    end
  endfunction

  // startup source still able to sink current
  function f_floor_ok;
    input [`AXD_SW-1:0] level;
    begin
      f_floor_ok = (level >= `AXD_FLOOR);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  wire [`AXD_SW-1:0] sense;
  wire               cmp;

  axd_sync u_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .din    (LINE_SENSE_PIN),
    .dout   (sense)
  );

  axd_slope u_slope (
    .clk    (CLK),
    .arst_n (ARST_N),
    .sample (sense),
    .cmp_q  (cmp)
  );

  //////////////////////////////////////////////////////////////////////////
  reg                cmp_d1_q;
  reg                cmp_d1_d;
  reg [`AXD_TW-1:0]  timer_q;
  reg [`AXD_TW-1:0]  timer_d;
  reg                state_q;
  reg                state_d;
  reg                dc_q;
  reg                dc_d;
  reg                dis_q;
  reg                dis_d;
  wire               edge_seen;
  wire               expired;
  wire               above_floor;
  wire               enter_disch;
  wire               leave_disch;

  assign edge_seen   = f_toggle(cmp, cmp_d1_q); // see [R5]
  assign expired     = f_done(timer_q, PHASE_CYC); // see [R11]
  assign above_floor = f_floor_ok(sense);
  // an edge in the very cycle of expiry wins: the line is back
  assign enter_disch = ~edge_seen & expired & above_floor; // see [R13]
  // line return seen mid-burst ends it early to avoid heating
  assign leave_disch = edge_seen | ~above_floor | expired; // see [R10]

  //////////////////////////////////////////////////////////////////////////
  always @* begin
    cmp_d1_d = cmp;
  end

  // one timer serves both phases, cleared at every phase boundary
  always @* begin
    timer_d = timer_q;
    case (state_q)
      ST_DETECT: begin
        if (edge_seen) begin
          timer_d = T_ZERO; // see [R4]
        end else if (expired) begin
          timer_d = T_ZERO;
        end else begin
          timer_d = f_bump(timer_q);
        end
      end

      ST_DISCH: begin
        if (leave_disch) begin
          timer_d = T_ZERO; // see [R9]
        end else begin
          timer_d = f_bump(timer_q); // see [R9]
        end
      end

      default: begin
        timer_d = T_ZERO;
      end
    endcase
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_DETECT: begin
        if (enter_disch) begin
          state_d = ST_DISCH; // see [R13]
        end else begin
          state_d = ST_DETECT;
        end
      end

      ST_DISCH: begin
        if (leave_disch) begin
          state_d = ST_DETECT; // see [R13]
        end else begin
          state_d = ST_DISCH;
        end
      end

      default: begin
        state_d = ST_DETECT;
      end
    endcase
  end

  // below the floor the flag is still set, only the burst is skipped
  always @* begin
    dc_d = dc_q;
    case (state_q)
      ST_DETECT: begin
        if (edge_seen) begin
          dc_d = 1'b0; // see [R4]
        end else if (expired) begin
          dc_d = 1'b1; // see [R6]
        end else begin
          dc_d = dc_q;
        end
      end

      ST_DISCH: begin
        if (edge_seen) begin
          dc_d = 1'b0; // see [R4]
        end else begin
          dc_d = dc_q;
        end
      end

      default: begin
        dc_d = dc_q;
      end
    endcase
  end

  always @* begin
    dis_d = 1'b0;
    case (state_q)
      ST_DETECT: begin
        if (enter_disch) begin
          dis_d = 1'b1; // see [R12]
        end else begin
          dis_d = 1'b0;
        end
      end

      ST_DISCH: begin
        if (leave_disch) begin
          dis_d = 1'b0;
        end else begin
          dis_d = 1'b1; // see [R12]
        end
      end

      default: begin
        dis_d = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // reset value matches the idle comparator, so no false edge
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmp_d1_q <= 1'b0;
    end else begin
      cmp_d1_q <= cmp_d1_d;
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      timer_q <= T_ZERO;
    end else begin
      timer_q <= timer_d;
    end
  end

  // no mode input at all: unplug handling cannot be masked off
  always @(posedge CLK or negedge ARST_N) begin // see [R8]
    if (!ARST_N) begin
      state_q <= ST_DETECT;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dc_q <= 1'b0;
    end else begin
      dc_q <= dc_d;
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dis_q <= 1'b0;
    end else begin
      dis_q <= dis_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign SLOPE_COMPARE_OUT = cmp;
  assign DC_PRESENT_FLAG   = dc_q;
  assign DISCHARGE_CURRENT = dis_q;
  assign DISCHARGE_PHASE   = state_q;
endmodule
`default_nettype wire

// ---- tb/axd_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "axd_map.vh"
module axd_checker #(parameter int P = 600) (
  input wire logic               CLK,
  input wire logic               ARST_N,
  input wire logic [`AXD_SW-1:0] LINE_SENSE_PIN,
  input wire logic               SLOPE_COMPARE_OUT,
  input wire logic               DC_PRESENT_FLAG,
  input wire logic               DISCHARGE_CURRENT,
  input wire logic               DISCHARGE_PHASE
);
  logic [23:0] qt_q;
  logic [23:0] ph_q;
  // slack of two cycles covers sync and edge-detect delay
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      qt_q <= 24'h0;
      ph_q <= 24'h0;
    end else begin
      qt_q <= $changed(SLOPE_COMPARE_OUT) ? 24'h0 : qt_q + 24'h1;
      ph_q <= DISCHARGE_PHASE ? ph_q + 24'h1 : 24'h0;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sink_match_a: assert property (DISCHARGE_CURRENT == DISCHARGE_PHASE)
    else $error("sink");
  enter_dc_a: assert property ($rose(DISCHARGE_PHASE) |-> DC_PRESENT_FLAG)
    else $error("enter");
  edge_clear_a: assert property ($changed(SLOPE_COMPARE_OUT)
    |-> ##[0:3] (!DC_PRESENT_FLAG && !DISCHARGE_PHASE)) else $error("edge");
  quiet_dc_a: assert property ($rose(DC_PRESENT_FLAG) |-> qt_q >= P - 2)
    else $error("early");
  late_dc_a: assert property (qt_q > P + 2 |-> DC_PRESENT_FLAG)
    else $error("late");
  disch_len_a: assert property (ph_q <= P)
    else $error("long");
  det_gap_a: assert property ($fell(DISCHARGE_PHASE) && DC_PRESENT_FLAG
    |-> !DISCHARGE_PHASE [*8]) else $error("gap");
  floor_a: assert property ($rose(DISCHARGE_PHASE)
    |-> $past(LINE_SENSE_PIN, 3) >= `AXD_FLOOR) else $error("floor");
endmodule
`default_nettype wire

// ---- tb/axd_line.sv ----
`timescale 1ns/1ps
`default_nettype none
// mains seen as a rising sawtooth, or a held dc level
module axd_line (
  input  wire logic        clk,
  input  wire logic        ramp,
  input  wire logic [11:0] level,
  output var  logic [11:0] sense
);
  initial sense = 12'h000;
  always @(posedge clk)
    sense <= #1 (ramp ? sense + 12'h001 : level);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %s exp %0h got %0h", s, e, g); end end
module tb_top;
  localparam int P = 600;
  logic        clk;
  logic        arst_n;
  logic        ramp;
  logic [11:0] level;
  wire  [11:0] sense;
  wire         cmp, dc, sink, ph;
  int          err_total = 0;
  int          n_compared = 0;
  int          n;
  axd_line line_m (.clk(clk), .ramp(ramp), .level(level), .sense(sense));
  axd_x2_discharge #(.PHASE_CYC(24'h258)) DUT (.CLK(clk), .ARST_N(arst_n),
    .LINE_SENSE_PIN(sense), .SLOPE_COMPARE_OUT(cmp), .DC_PRESENT_FLAG(dc),
    .DISCHARGE_CURRENT(sink), .DISCHARGE_PHASE(ph));
  task automatic conclude();
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic span(input logic v);
    n = 0;
    while (ph === v && n < 2 * P) begin
      tick(1);
      n++;
    end
    if (n >= 2 * P) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic t_dc();
    ramp = 1'b0;
    level = 12'h800;
    span(1'b0);
    `CHK("sink", 1'b1, sink)
    span(1'b1);
    `CHK("burst", 1'b1, n >= P - 1 && n <= P + 1)
    `CHK("dc", 1'b1, dc)
    span(1'b0);
    `CHK("gap", 1'b1, n >= P - 1 && n <= P + 1)
  endtask
  task automatic t_back();
    ramp = 1'b1;
    span(1'b1);
    tick(4);
    `CHK("stop", 1'b1, n < 300)
    `CHK("dc", 1'b0, dc)
  endtask
  task automatic t_low();
    ramp = 1'b0;
    level = 12'h030;
    tick(3 * P);
    `CHK("dc", 1'b1, dc)
    `CHK("phase", 1'b0, ph)
    `CHK("cmp", 1'b0, cmp)
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    ramp = 1'b1;
    level = 12'h000;
    tick(4);
    arst_n = 1'b1;
    tick(3 * P);
    `CHK("ac", 1'b0, dc | sink)
    t_dc();
    t_back();
    t_low();
    conclude();
  end
endmodule
bind axd_x2_discharge axd_checker #(.P(600)) chk (.*);
`default_nettype wire
